// *** core/fwac_pkg.sv ***
// constants, register layout and state type of the flash write access control
// assumes a single 50 MHz system clock and a fixed timing-generator divider
package fwac_pkg;

	// clock and timing generator
	localparam int          SYS_CLK_KHZ  = 50000;
	localparam int          TG_CLK_KHZ   = 400;
	localparam int          TG_DIV       = SYS_CLK_KHZ / TG_CLK_KHZ;
	localparam logic [6:0]  TG_DIV_LAST  = 7'(TG_DIV - 1);
	localparam int          CNT_W        = 13;
	localparam logic [12:0] WORD_TG      = 13'h001e;
	localparam logic [12:0] BLK_WORD_TG  = 13'h0019;
	localparam int          ERASE_TG_DEF = 4800;
	localparam logic [4:0]  SLICE_LAST   = 5'h1f;

	// block geometry: 64 bytes, 32 words
	localparam int          BLK_BYTES    = 64;
	localparam logic [4:0]  BLK_LAST     = 5'(BLK_BYTES / 2 - 1);

	// register indices, write password and read key
	localparam logic [1:0]  REG_CTL1     = 2'h0;
	localparam logic [1:0]  REG_CTL3     = 2'h1;
	localparam logic [1:0]  REG_CTLI     = 2'h2;
	localparam logic [7:0]  WR_PASSWORD  = 8'ha5;
	localparam logic [7:0]  RD_KEY       = 8'h96;

	// field positions
	localparam int          C1_ERASE     = 1;
	localparam int          C1_WRT       = 6;
	localparam int          C1_BLK       = 7;
	localparam int          C3_BUSY      = 0;
	localparam int          C3_KEY_VIOLATION_FLAG      = 1;
	localparam int          C3_ACCV      = 2;
	localparam int          C3_WAIT      = 3;
	localparam int          C3_LOCK      = 4;
	localparam int          C3_EMERGENCY_EXIT_BIT      = 5;
	localparam int          C3_FAIL      = 7;
	localparam int          CI_EEI       = 0;
	localparam int          CI_INTERRUPT_ABORT_ENABLE     = 1;
	localparam int          CI_ACCESS_VIOLATION_IRQ_ENABLE    = 2;

	// reset values and fixed data
	localparam logic        LOCK_RST     = 1'h1;
	localparam logic        WAIT_RST     = 1'h1;
	localparam logic [15:0] JUMP_OP      = 16'h3fff;

	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_OP   = 2'h1,
		S_SUSP = 2'h3,
		S_BLK  = 2'h2
	} fwac_state_t;

endpackage : fwac_pkg

// *** core/fwac_tg_if.sv ***
// link between the sequencer and the timing generator
// assumes both ends run on sys_clk
interface fwac_tg_if;
	logic                       start;
	logic                       hold;
	logic                       stop;
	logic [fwac_pkg::CNT_W-1:0] len;
	logic                       done;
	logic                       slice;
	modport gen (input start, input hold, input stop, input len, output done, output slice);
	modport ctl (output start, output hold, output stop, output len, input done, input slice);
endinterface : fwac_tg_if

// *** core/fwac_tgen.sv ***
// timing generator: divider enable and operation length counter
// assumes start, hold and stop come from same-clock logic
module fwac_tgen (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// timing control
	fwac_tg_if.gen   tg
);
	logic [6:0]                 div_q;
	logic                       tick_q;
	logic                       run_q;
	logic [fwac_pkg::CNT_W-1:0] cnt_q;
	logic [4:0]                 slc_q;
	logic                       done_q;
	logic                       slice_q;

	wire div_wrap = (div_q == fwac_pkg::TG_DIV_LAST);
	wire step     = tick_q && run_q && !tg.hold && !tg.stop;
	wire last     = (cnt_q == fwac_pkg::CNT_W'(1));
	wire slc_wrap = (slc_q == fwac_pkg::SLICE_LAST);

	assign tg.done  = done_q;
	assign tg.slice = slice_q;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			div_q  <= 7'h00;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_wrap ? 7'h00 : div_q + 7'h01;
			tick_q <= div_wrap;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			run_q   <= 1'b0;
			cnt_q   <= '0;
			slc_q   <= 5'h00;
			done_q  <= 1'b0;
			slice_q <= 1'b0;
		end else begin
			done_q  <= step && last;
			slice_q <= step && slc_wrap;
			if (tg.stop) begin
				run_q <= 1'b0;
			end else if (tg.start) begin
				run_q <= 1'b1;
				cnt_q <= tg.len;
				slc_q <= 5'h00;
			end else if (tg.hold) begin
				// a resumed erase always gets a full slice
				slc_q <= 5'h00;
			end else if (step) begin
				cnt_q <= cnt_q - fwac_pkg::CNT_W'(1);
				slc_q <= slc_q + 5'h01;
				if (last) begin
					run_q <= 1'b0;
				end
			end
		end
	end

endmodule : fwac_tgen

// *** core/fwac_access.sv ***
// classifies one cpu flash access against the current operation
// assumes all inputs are same-clock, output is purely combinational
module fwac_access (
	// operation state
	input  wire logic is_op,
	input  wire logic is_blk,
	input  wire logic is_susp,
	input  wire logic op_from_flash,
	input  wire logic wait_rdy,
	input  wire logic write_enable_bit,
	input  wire logic erase_bit,
	input  wire logic lock_bit,
	// cpu access
	input  wire logic req,
	input  wire logic req_we,
	input  wire logic req_fetch,
	// verdict
	output wire logic viol,
	output wire logic lock_set,
	output wire logic jump,
	output wire logic idle_wr,
	output wire logic blk_wr
);
	wire idle    = !is_op && !is_blk && !is_susp;
	wire wr_bad  = (!write_enable_bit && !erase_bit) || lock_bit;
	wire op_ram  = is_op && !op_from_flash;
	wire op_fl   = is_op && op_from_flash;
	wire blk_lo  = is_blk && !wait_rdy;
	wire blk_hi  = is_blk && wait_rdy;
	wire idle_v  = idle && req_we && wr_bad;
	wire op_v    = op_ram || (op_fl && req_we);
	wire blk_v   = blk_lo || (blk_hi && req_fetch);

	assign viol     = req && (idle_v || op_v || blk_v);
	assign lock_set = req && blk_v;
	assign jump     = is_op || is_blk;
	assign idle_wr  = req && idle && req_we && !wr_bad;
	assign blk_wr   = req && blk_hi && req_we;
endmodule : fwac_access

// *** core/fwac_top.sv ***
// flash write access control: write/erase sequencing, cpu arbitration
// assumes the cpu port and interrupt inputs are on sys_clk
// Contract
// - programming voltage stays on through the whole 64-byte block write
// - busy high for the whole block, cleared when each block completes
// - wait flag high when next word is accepted; cpu polls it
// - flash access during a ram-started busy operation flags violation
// - flash write with write enable and erase both clear flags violation, flash untouched
// - fetches see the self-jump opcode until a flash-started operation ends
// - busy erase or word write: reads give 3fff, writes dropped and flagged
// - block write with wait low: any access sets violation and lock
// - block wait high: reads 3fff, writes taken, fetch sets violation and lock
// - both interrupt controls clear: interrupts masked during operations
// - abort control and global enable: interrupt aborts and sets failure
// - interruptible erase yields every 32 generator cycles, resumes 32 more
// - during a suspended erase busy stays set, accesses not flagged
// - any reset aborts an erase; software stops watchdog first
// - emergency exit halts everything and clears the first control register
// - write enable alone selects word writes, with block mode block write
// - control writes need password a5 in upper byte, else key violation
// - first control register write in block mode allowed only with wait high
// - violation flag sticky until cleared, enable raises non-maskable request
module fwac_top #(
	parameter int unsigned ERASE_TG = fwac_pkg::ERASE_TG_DEF
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// register port
	input  wire logic [1:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output      logic [15:0] reg_rdata,
	// cpu flash port
	input  wire logic        fl_req,
	input  wire logic        fl_we,
	input  wire logic        fl_fetch,
	input  wire logic        cpu_in_flash,
	input  wire logic [14:0] fl_addr,
	input  wire logic [15:0] fl_wdata,
	output      logic [15:0] fl_rdata,
	output      logic        fl_rvalid,
	// flash array
	output      logic [14:0] arr_addr,
	output      logic [15:0] arr_wdata,
	output      logic        arr_we,
	output      logic        arr_re,
	output      logic        arr_erase,
	output      logic        arr_prog_on,
	input  wire logic [15:0] arr_rdata,
	// interrupt side
	input  wire logic        irq_pending,
	input  wire logic        global_irq_enable,
	input  wire logic        irq_service_done,
	output      logic        irq_mask,
	output      logic        erase_suspended,
	output      logic        access_violation_nmi,
	output      logic        power_up_clear_reset
);
	localparam logic [fwac_pkg::CNT_W-1:0] ERASE_LEN = ERASE_TG[fwac_pkg::CNT_W-1:0];

	fwac_tg_if tg ();

	fwac_pkg::fwac_state_t state_q;
	fwac_pkg::fwac_state_t state_d;

	logic        write_enable_bit_q;
	logic        block_mode_bit_q;
	logic        erase_q;
	logic        lock_q;
	logic        wait_q;
	logic        access_violation_flag_q;
	logic        key_violation_flag_q;
	logic        fail_q;
	logic        erase_interruptible_enable_q;
	logic        interrupt_abort_enable_q;
	logic        access_violation_irq_enable_q;
	logic        from_flash_q;
	logic [4:0]  wcnt_q;
	logic [15:0] reg_rdata_q;
	logic [15:0] fl_rdata_q;
	logic        fl_rvalid_q;
	logic        rd_pend_q;
	logic        jmp_pend_q;
	logic [14:0] arr_addr_q;
	logic [15:0] arr_wdata_q;
	logic        arr_we_q;
	logic        arr_re_q;
	logic        puc_q;

	// access verdict
	logic viol;
	logic lock_set;
	logic jump;
	logic idle_wr;
	logic blk_wr;

	wire is_op   = (state_q == fwac_pkg::S_OP);
	wire is_blk  = (state_q == fwac_pkg::S_BLK);
	wire is_susp = (state_q == fwac_pkg::S_SUSP);
	wire busy    = (state_q != fwac_pkg::S_IDLE);

	fwac_access u_access (
		.is_op            (is_op),
		.is_blk           (is_blk),
		.is_susp          (is_susp),
		.op_from_flash    (from_flash_q),
		.wait_rdy         (wait_q),
		.write_enable_bit (write_enable_bit_q),
		.erase_bit        (erase_q),
		.lock_bit         (lock_q),
		.req              (fl_req),
		.req_we           (fl_we),
		.req_fetch        (fl_fetch),
		.viol             (viol),
		.lock_set         (lock_set),
		.jump             (jump),
		.idle_wr          (idle_wr),
		.blk_wr           (blk_wr)
	);

	fwac_tgen u_tgen (
		.sys_clk (sys_clk),
		.reset   (reset),
		.tg      (tg.gen)
	);

	// register decode
	wire key_ok    = (reg_wdata[15:8] == fwac_pkg::WR_PASSWORD);
	wire mapped    = (reg_addr != 2'h3);
	wire key_bad   = reg_we && mapped && !key_ok;
	wire wr_ctl1   = reg_we && key_ok && (reg_addr == fwac_pkg::REG_CTL1);
	wire wr_ctl3   = reg_we && key_ok && (reg_addr == fwac_pkg::REG_CTL3);
	wire wr_ctli   = reg_we && key_ok && (reg_addr == fwac_pkg::REG_CTLI);
	wire c1_viol   = wr_ctl1 && (is_op || (is_blk && !wait_q));
	wire c1_ok     = wr_ctl1 && !c1_viol;
	wire emergency_exit_bit      = wr_ctl3 && reg_wdata[fwac_pkg::C3_EMERGENCY_EXIT_BIT];

	// operation control
	wire irq_abort = busy && interrupt_abort_enable_q
		&& global_irq_enable && irq_pending;
	wire kill      = emergency_exit_bit || irq_abort;
	wire may_susp  = erase_q && erase_interruptible_enable_q
		&& !interrupt_abort_enable_q && global_irq_enable;
	wire suspend   = is_op && may_susp && tg.slice && irq_pending;
	wire blk_last  = (wcnt_q == fwac_pkg::BLK_LAST);
	wire blk_end   = is_blk && ((tg.done && blk_last) || (wait_q && !block_mode_bit_q));
	wire start_blk = idle_wr && !erase_q && block_mode_bit_q;
	wire start_op  = idle_wr && !start_blk;

	// flag events; a set always beats a software clear
	wire accv_set  = viol || c1_viol;
	wire accv_clr  = wr_ctl3 && !reg_wdata[fwac_pkg::C3_ACCV];
	wire fail_clr  = wr_ctl3 && !reg_wdata[fwac_pkg::C3_FAIL];
	wire key_violation_flag_clr  = wr_ctl3 && !reg_wdata[fwac_pkg::C3_KEY_VIOLATION_FLAG];

	assign tg.start = !kill && (start_op || start_blk || blk_wr);
	assign tg.len   = erase_q ? ERASE_LEN
		: (block_mode_bit_q ? fwac_pkg::BLK_WORD_TG : fwac_pkg::WORD_TG);
	assign tg.hold  = is_susp;
	assign tg.stop  = kill;

	always_comb begin
		state_d = state_q;
		case (state_q)
			fwac_pkg::S_IDLE: begin
				if (start_blk) begin
					state_d = fwac_pkg::S_BLK;
				end else if (start_op) begin
					state_d = fwac_pkg::S_OP;
				end
			end
			fwac_pkg::S_OP: begin
				if (kill || tg.done) begin
					state_d = fwac_pkg::S_IDLE;
				end else if (suspend) begin
					state_d = fwac_pkg::S_SUSP;
				end
			end
			fwac_pkg::S_SUSP: begin
				if (kill) begin
					state_d = fwac_pkg::S_IDLE;
				end else if (irq_service_done) begin
					state_d = fwac_pkg::S_OP;
				end
			end
			fwac_pkg::S_BLK: begin
				if (kill || blk_end) begin
					state_d = fwac_pkg::S_IDLE;
				end
			end
			default: begin
				state_d = fwac_pkg::S_IDLE;
			end
		endcase
	end

	// reset aborts any operation in flight
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q <= fwac_pkg::S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// first control register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			write_enable_bit_q <= 1'b0;
			block_mode_bit_q   <= 1'b0;
			erase_q            <= 1'b0;
		end else if (emergency_exit_bit) begin
			write_enable_bit_q <= 1'b0;
			block_mode_bit_q   <= 1'b0;
			erase_q            <= 1'b0;
		end else if (c1_ok) begin
			write_enable_bit_q <= reg_wdata[fwac_pkg::C1_WRT];
			block_mode_bit_q   <= reg_wdata[fwac_pkg::C1_BLK];
			erase_q            <= reg_wdata[fwac_pkg::C1_ERASE];
		end else if (is_op && tg.done && erase_q) begin
			erase_q            <= 1'b0;
		end
	end

	// third control register and interrupt controls
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lock_q                        <= fwac_pkg::LOCK_RST;
			access_violation_flag_q       <= 1'b0;
			key_violation_flag_q          <= 1'b0;
			fail_q                        <= 1'b0;
			erase_interruptible_enable_q  <= 1'b0;
			interrupt_abort_enable_q      <= 1'b0;
			access_violation_irq_enable_q <= 1'b0;
			puc_q                         <= 1'b0;
		end else begin
			lock_q <= lock_set || (wr_ctl3 ? reg_wdata[fwac_pkg::C3_LOCK] : lock_q);
			access_violation_flag_q <= accv_set
				|| (access_violation_flag_q && !accv_clr);
			key_violation_flag_q <= key_bad || (key_violation_flag_q && !key_violation_flag_clr);
			fail_q <= irq_abort || (fail_q && !fail_clr);
			puc_q  <= key_bad;
			if (wr_ctli) begin
				erase_interruptible_enable_q  <= reg_wdata[fwac_pkg::CI_EEI];
				interrupt_abort_enable_q      <= reg_wdata[fwac_pkg::CI_INTERRUPT_ABORT_ENABLE];
				access_violation_irq_enable_q <= reg_wdata[fwac_pkg::CI_ACCESS_VIOLATION_IRQ_ENABLE];
			end
		end
	end

	// operation bookkeeping
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wait_q       <= fwac_pkg::WAIT_RST;
			from_flash_q <= 1'b0;
			wcnt_q       <= 5'h00;
		end else if (kill || blk_end) begin
			wait_q       <= 1'b1;
		end else if (start_op) begin
			from_flash_q <= cpu_in_flash;
		end else if (start_blk) begin
			// block starts from ram only; reads still get the jump opcode, since jump covers is_blk
			from_flash_q <= 1'b0;
			wait_q       <= 1'b0;
			wcnt_q       <= 5'h00;
		end else if (blk_wr) begin
			wait_q       <= 1'b0;
			wcnt_q       <= wcnt_q + 5'h01;
		end else if (is_blk && tg.done) begin
			wait_q       <= 1'b1;
		end
	end

	// array side: writes only for accepted accesses, erase dummy write is not stored
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			arr_addr_q  <= 15'h0000;
			arr_wdata_q <= 16'h0000;
			arr_we_q    <= 1'b0;
			arr_re_q    <= 1'b0;
		end else begin
			arr_we_q <= !kill && ((start_op && !erase_q) || start_blk || blk_wr);
			arr_re_q <= fl_req && !fl_we && (!jump || is_susp);
			if (fl_req) begin
				arr_addr_q  <= fl_addr;
				arr_wdata_q <= fl_wdata;
			end
		end
	end

	// cpu read pipe: request, array access, data
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rd_pend_q   <= 1'b0;
			jmp_pend_q  <= 1'b0;
			fl_rdata_q  <= 16'h0000;
			fl_rvalid_q <= 1'b0;
		end else begin
			rd_pend_q   <= fl_req && !fl_we;
			jmp_pend_q  <= jump;
			fl_rvalid_q <= rd_pend_q;
			if (rd_pend_q) begin
				fl_rdata_q <= jmp_pend_q ? fwac_pkg::JUMP_OP : arr_rdata;
			end
		end
	end

	// register read, one cycle after the strobe
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_rdata_q <= 16'h0000;
		end else if (reg_re) begin
			case (reg_addr)
				fwac_pkg::REG_CTL1: begin
					reg_rdata_q <= {fwac_pkg::RD_KEY, block_mode_bit_q,
						write_enable_bit_q, 4'h0, erase_q, 1'b0};
				end
				fwac_pkg::REG_CTL3: begin
					reg_rdata_q <= {fwac_pkg::RD_KEY, fail_q, 2'h0, lock_q,
						wait_q, access_violation_flag_q, key_violation_flag_q, busy};
				end
				fwac_pkg::REG_CTLI: begin
					reg_rdata_q <= {13'h0000, access_violation_irq_enable_q,
						interrupt_abort_enable_q, erase_interruptible_enable_q};
				end
				default: begin
					reg_rdata_q <= 16'h0000;
				end
			endcase
		end else begin
			reg_rdata_q <= 16'h0000;
		end
	end

	// outputs
	assign reg_rdata            = reg_rdata_q;
	assign fl_rdata             = fl_rdata_q;
	assign fl_rvalid            = fl_rvalid_q;
	assign arr_addr             = arr_addr_q;
	assign arr_wdata            = arr_wdata_q;
	assign arr_we               = arr_we_q;
	assign arr_re               = arr_re_q;
	assign arr_erase            = is_op && erase_q;
	// voltage kept up across the block instead of per word: 25 instead of 30 generator cycles per word
	assign arr_prog_on          = is_blk || (is_op && !erase_q);
	assign erase_suspended      = is_susp;
	// pending interrupts stay flagged outside; they fire once unmasked
	assign irq_mask             = (is_op || is_blk)
		&& !(interrupt_abort_enable_q && global_irq_enable);
	assign access_violation_nmi = access_violation_flag_q
		&& access_violation_irq_enable_q;
	assign power_up_clear_reset = puc_q;

endmodule : fwac_top

// *** tb/fwac_array_model.sv ***
// flash array stand-in for the far side of fwac_top
// assumes the design samples arr_rdata at the end of the cycle in which arr_re is high
module fwac_array_model (
	// clock
	input  wire logic        sys_clk,
	// array side
	input  wire logic        arr_re,
	input  wire logic [14:0] arr_addr,
	output      logic [15:0] arr_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] junk_q;
	initial junk_q = 16'h0000;
	always @(posedge sys_clk) begin
		junk_q <= ~junk_q;
	end
	// answers within the read cycle; toggling filler otherwise so stale data never passes
	assign arr_rdata = arr_re ? ({1'b0, arr_addr} ^ 16'h1234) : junk_q;
endmodule : fwac_array_model

// *** tb/fwac_top_assertions.sv ***
// port-level checks of fwac_top
// assumes a single sys_clk domain and the async active-high reset
module fwac_chk #(
	parameter int unsigned ERASE_TG = fwac_pkg::ERASE_TG_DEF
) (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        reset,
	// register port
	input wire logic [1:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_we,
	input wire logic        reg_re,
	input wire logic [15:0] reg_rdata,
	// flash port and array
	input wire logic        fl_req,
	input wire logic        fl_we,
	input wire logic        fl_rvalid,
	input wire logic        arr_we,
	input wire logic        arr_erase,
	input wire logic        arr_prog_on,
	// interrupt side
	input wire logic        global_irq_enable,
	input wire logic        irq_mask,
	input wire logic        erase_suspended,
	input wire logic        power_up_clear_reset
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire bad_key = reg_we && reg_addr != 2'h3 && reg_wdata[15:8] != fwac_pkg::WR_PASSWORD;
	wire emergency_exit_bit_wr = reg_we && reg_addr == fwac_pkg::REG_CTL3
		&& reg_wdata[15:8] == fwac_pkg::WR_PASSWORD && reg_wdata[fwac_pkg::C3_EMERGENCY_EXIT_BIT];
	a_key_puc: assert property (bad_key |=> power_up_clear_reset)
		else $error("no reset pulse after bad password");
	a_puc_cause: assert property (power_up_clear_reset |-> $past(reg_we))
		else $error("reset pulse without a register write");
	a_rdkey_ctl3: assert property (reg_re && reg_addr == fwac_pkg::REG_CTL3 |=>
		reg_rdata[15:8] == fwac_pkg::RD_KEY) else $error("read key wrong");
	a_arr_we_cause: assert property (arr_we |-> $past(fl_req && fl_we))
		else $error("array write without a cpu write");
	a_prog_with_we: assert property (arr_we |-> arr_prog_on)
		else $error("array write without programming voltage");
	a_read_answer: assert property (fl_req && !fl_we |-> ##2 fl_rvalid)
		else $error("flash read not answered");
	a_emergency_exit_bit_stop: assert property (emergency_exit_bit_wr |=> !arr_prog_on && !arr_erase)
		else $error("emergency exit left operation running");
	a_mask_in_op: assert property ((arr_prog_on || arr_erase) && !global_irq_enable
		|-> irq_mask) else $error("interrupts open during operation");
	a_susp_idle: assert property (erase_suspended |-> !arr_erase && !arr_prog_on)
		else $error("array busy while erase suspended");
	c_arr_we: cover property (arr_we);
	c_susp: cover property ($rose(erase_suspended));
	c_puc: cover property (power_up_clear_reset);
	c_rvalid: cover property (fl_rvalid);
endmodule : fwac_chk

bind fwac_top fwac_chk #(.ERASE_TG(ERASE_TG)) u_chk (.sys_clk, .reset, .reg_addr, .reg_wdata,
	.reg_we, .reg_re, .reg_rdata, .fl_req, .fl_we, .fl_rvalid, .arr_we, .arr_erase, .arr_prog_on,
	.global_irq_enable, .irq_mask, .erase_suspended, .power_up_clear_reset);

// *** tb/fwac_top_tb_top.sv ***
// self-checking bench for fwac_top: register and flash port tasks
// assumes fwac_array_model on the array side and a 50 MHz sys_clk
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module fwac_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk, reset, reg_we, reg_re, fl_req, fl_we, fl_fetch, cpu_in_flash;
	logic        fl_rvalid, arr_we, arr_re, arr_erase, arr_prog_on, irq_pending, we;
	logic        global_irq_enable, irq_service_done, irq_mask, erase_suspended;
	logic        access_violation_nmi, power_up_clear_reset;
	logic [1:0]  reg_addr;
	logic [14:0] fl_addr, arr_addr;
	logic [15:0] reg_wdata, reg_rdata, fl_wdata, fl_rdata, arr_wdata, arr_rdata, r, d;
	int          n_mismatch, cmp_count;

	// short erase so a slice and the resume fit in the run
	fwac_top #(.ERASE_TG(40)) u_dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_we,
		.reg_re, .reg_rdata, .fl_req, .fl_we, .fl_fetch, .cpu_in_flash, .fl_addr, .fl_wdata,
		.fl_rdata, .fl_rvalid, .arr_addr, .arr_wdata, .arr_we, .arr_re, .arr_erase,
		.arr_prog_on, .arr_rdata, .irq_pending, .global_irq_enable, .irq_service_done,
		.irq_mask, .erase_suspended, .access_violation_nmi, .power_up_clear_reset);
	fwac_array_model u_arr (.sys_clk, .arr_re, .arr_addr, .arr_rdata);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic wr(input logic [1:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rdq(input logic [1:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_re <= 1'b0;
		#1 v = reg_rdata;
	endtask : rdq

	task automatic rd(input logic [1:0] a, input logic [15:0] e);
		logic [15:0] x;
		rdq(a, x);
		`CHK("reg_rdata", e, x)
	endtask : rd

	// read kinds give back fl_rdata and fl_rvalid one edge after the request edge
	task automatic fl(input logic w, f, input logic [14:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		fl_req <= 1'b1;
		fl_we <= w;
		fl_fetch <= f;
		fl_addr <= a;
		fl_wdata <= v;
		@(posedge sys_clk);
		fl_req <= 1'b0;
		#1 we = arr_we;
		r = 16'h0000;
		if (!w) begin
			@(posedge sys_clk);
			#1 r = fl_rdata;
			`CHK("fl_rvalid", 1'b1, fl_rvalid)
		end
	endtask : fl

	task automatic poll(input int b, input logic v);
		for (int i = 0; i < 6000; i++) begin
			rdq(fwac_pkg::REG_CTL3, d);
			if (d[b] === v) return;
		end
		`CHK("ctl3 poll", v, d[b])
	endtask : poll

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#1_200_000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		reset = 1'b1;
		{reg_we, reg_re, fl_req, fl_we, fl_fetch, cpu_in_flash} = '0;
		{irq_pending, global_irq_enable, irq_service_done} = '0;
		{reg_addr, reg_wdata, fl_addr, fl_wdata} = '0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		rd(fwac_pkg::REG_CTL1, 16'h9600);
		rd(fwac_pkg::REG_CTL3, 16'h9618);
		rd(fwac_pkg::REG_CTLI, 16'h0000);
		rd(2'h3, 16'h0000);
		wr(fwac_pkg::REG_CTL3, 16'ha500);
		fl(1'b1, 1'b0, 15'h0100, 16'h0123);
		`CHK("arr_we", 1'b0, we)
		rd(fwac_pkg::REG_CTL3, 16'h960c);
		wr(fwac_pkg::REG_CTLI, 16'ha504);
		rd(fwac_pkg::REG_CTLI, 16'h0004);
		`CHK("nmi", 1'b1, access_violation_nmi)
		wr(fwac_pkg::REG_CTLI, 16'ha500);
		wr(fwac_pkg::REG_CTL3, 16'ha500);
		$display("test reset and write-disabled done");
		cpu_in_flash <= 1'b1;
		wr(fwac_pkg::REG_CTL1, 16'ha540);
		fl(1'b1, 1'b0, 15'h0010, 16'h0123);
		`CHK("arr_we", 1'b1, we)
		`CHK("arr_wdata", 16'h0123, arr_wdata)
		fl(1'b0, 1'b1, 15'h0011, 16'h0000);
		`CHK("fetch", fwac_pkg::JUMP_OP, r)
		`CHK("irq_mask", 1'b1, irq_mask)
		fl(1'b0, 1'b0, 15'h0012, 16'h0000);
		`CHK("read", fwac_pkg::JUMP_OP, r)
		rdq(fwac_pkg::REG_CTL3, d);
		`CHK("accv", 1'b0, d[fwac_pkg::C3_ACCV])
		fl(1'b1, 1'b0, 15'h0013, 16'h0000);
		`CHK("arr_we", 1'b0, we)
		rdq(fwac_pkg::REG_CTL3, d);
		`CHK("accv", 1'b1, d[fwac_pkg::C3_ACCV])
		poll(fwac_pkg::C3_BUSY, 1'b0);
		fl(1'b0, 1'b1, 15'h0014, 16'h0000);
		`CHK("fetch", 16'h1220, r)
		wr(fwac_pkg::REG_CTL3, 16'ha500);
		cpu_in_flash <= 1'b0;
		$display("test word write done");
		wr(fwac_pkg::REG_CTL1, 16'ha5c0);
		fl(1'b1, 1'b0, 15'h0200, 16'h1111);
		`CHK("arr_we", 1'b1, we)
		rdq(fwac_pkg::REG_CTL3, d);
		`CHK("busy", 1'b1, d[fwac_pkg::C3_BUSY])
		`CHK("wait", 1'b0, d[fwac_pkg::C3_WAIT])
		poll(fwac_pkg::C3_WAIT, 1'b1);
		`CHK("prog_on", 1'b1, arr_prog_on)
		fl(1'b0, 1'b0, 15'h0201, 16'h0000);
		`CHK("read", fwac_pkg::JUMP_OP, r)
		fl(1'b1, 1'b0, 15'h0201, 16'h2222);
		`CHK("arr_we", 1'b1, we)
		fl(1'b0, 1'b0, 15'h0202, 16'h0000);
		rdq(fwac_pkg::REG_CTL3, d);
		`CHK("accv lock", 2'h3, {d[fwac_pkg::C3_ACCV], d[fwac_pkg::C3_LOCK]})
		wr(fwac_pkg::REG_CTL3, 16'ha520);
		rd(fwac_pkg::REG_CTL1, 16'h9600);
		`CHK("prog_on", 1'b0, arr_prog_on)
		wr(fwac_pkg::REG_CTL3, 16'ha500);
		wr(fwac_pkg::REG_CTL1, 16'ha5c0);
		fl(1'b1, 1'b0, 15'h0240, 16'h3333);
		poll(fwac_pkg::C3_WAIT, 1'b1);
		wr(fwac_pkg::REG_CTL1, 16'ha500);
		rdq(fwac_pkg::REG_CTL3, d);
		`CHK("busy accv", 2'h0, {d[fwac_pkg::C3_BUSY], d[fwac_pkg::C3_ACCV]})
		$display("test block write done");
		wr(fwac_pkg::REG_CTLI, 16'ha501);
		global_irq_enable <= 1'b1;
		irq_pending <= 1'b1;
		wr(fwac_pkg::REG_CTL1, 16'ha502);
		fl(1'b1, 1'b0, 15'h0300, 16'h0000);
		for (int i = 0; i < 6000 && erase_suspended !== 1'b1; i++) @(posedge sys_clk);
		`CHK("suspended", 1'b1, erase_suspended)
		fl(1'b0, 1'b0, 15'h0301, 16'h0000);
		`CHK("read", 16'h1135, r)
		rdq(fwac_pkg::REG_CTL3, d);
		`CHK("busy accv", 2'h2, {d[fwac_pkg::C3_BUSY], d[fwac_pkg::C3_ACCV]})
		irq_pending <= 1'b0;
		irq_service_done <= 1'b1;
		@(posedge sys_clk);
		irq_service_done <= 1'b0;
		poll(fwac_pkg::C3_BUSY, 1'b0);
		wr(fwac_pkg::REG_CTLI, 16'ha502);
		irq_pending <= 1'b1;
		wr(fwac_pkg::REG_CTL1, 16'ha540);
		fl(1'b1, 1'b0, 15'h0400, 16'h5555);
		rdq(fwac_pkg::REG_CTL3, d);
		`CHK("fail busy", 2'h2, {d[fwac_pkg::C3_FAIL], d[fwac_pkg::C3_BUSY]})
		irq_pending <= 1'b0;
		global_irq_enable <= 1'b0;
		$display("test erase suspend done");
		wr(fwac_pkg::REG_CTL1, 16'h1200);
		rdq(fwac_pkg::REG_CTL3, d);
		`CHK("key_violation_flag", 1'b1, d[fwac_pkg::C3_KEY_VIOLATION_FLAG])
		$display("test key violation done");
		print_verdict();
	end
endmodule : fwac_top_tb_top
